//--- verilog/prr_exec.sv
`timescale 1ns/1ps
// Function
// - Port write drives port address and data word onto external buses.
// - Repeated port write steps port address by one and counts repeats down.
// - I/O space select is driven low during a port write.
// - Strobe and write level follow a data write; ready stretches it.
// - A port write lasts three cycles plus configured wait states.
// - Port write takes a 16-bit second-word operand; PC advances two.
// - Interrupt return loads PC from stack top and pops once.
// - Interrupt return copies shadow values back into working registers.
// - Shadowed set is accumulator, buffer, product, status, mode, aux, temps.
// - External flag bit is neither saved nor restored by shadowing.
// - Left rotate turns the 65-bit carry chain; sign extension ignored.
// - Left rotate puts the old accumulator top bit into carry.
// - Left rotate: carry into buffer bit 0, buffer top into accumulator.
// - A repeat instruction is never itself repeated.
module prr_exec
  import prr_pkg::*;
#(
  parameter int STACK_LEVELS = STACK_DEPTH,
  parameter int WAIT_BITS = WAIT_W
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic OP_VALID,
  output logic OP_READY,
  input wire prr_pkg::prr_op_t OP_CODE,
  input wire logic [prr_pkg::ADDR_W-1:0] OP_OPERAND,
  input wire logic [3:0] OP_COND_MASK,
  input wire logic [3:0] OP_COND_VAL,
  input wire logic [1:0] OP_COND_TP,
  input wire logic [prr_pkg::DATA_W-1:0] OP_DATA,
  output logic DATA_NEXT,
  input wire logic [WAIT_BITS-1:0] WAIT_STATES,
  input wire logic INT_TAKE,
  input wire logic [prr_pkg::ADDR_W-1:0] INT_VECTOR,
  input wire logic REG_WR,
  input wire logic [prr_pkg::REG_SEL_W-1:0] REG_SEL,
  input wire logic [prr_pkg::ACC_W-1:0] REG_WDATA,
  output logic [prr_pkg::ACC_W-1:0] REG_RD_DATA,
  output logic [prr_pkg::ADDR_W-1:0] PC_OUT,
  output logic [prr_pkg::ADDR_W-1:0] STACK_TOP,
  output logic XF_OUT,
  output logic [prr_pkg::ADDR_W-1:0] ADDR_BUS,
  output logic [prr_pkg::DATA_W-1:0] DATA_BUS_O,
  output logic DATA_BUS_OE,
  output logic IO_SPACE_SELECT_N,
  output logic EXTERNAL_STROBE_N,
  output logic RW,
  input wire logic READY,
  input wire logic BIO_N
);

  import prr_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_EXEC, ST_OUT_ADDR, ST_OUT_EXTERNAL_STROBE, ST_OUT_END
  } prr_state_t;

  if (STACK_LEVELS < 2 || WAIT_BITS < 1) begin : g_chk
    $error("prr_exec parameters out of range");
  end

  prr_state_t state_q, state_d;
  prr_op_t op_q, op_d;
  logic [15:0] opnd_q, opnd_d, port_q, port_d, rpt_q, rpt_d;
  logic [15:0] pc_q, pc_d, tgt_q, tgt_d, addr_q, addr_d, dout_q, dout_d;
  logic [3:0] cmask_q, cmask_d, cval_q, cval_d;
  logic [1:0] ctp_q, ctp_d, dly_q, dly_d, words;
  logic [WAIT_BITS-1:0] wait_q, wait_d;
  logic [ACC_W-1:0] wr_q [NREG];
  logic [ACC_W-1:0] wr_d [NREG];
  logic [ACC_W-1:0] sh_q [NREG];
  logic [ACC_W-1:0] sh_d [NREG];
  logic [ACC_W-1:0] rd_q, rd_d, acc, sum_buffer_register;
  logic oe_q, oe_d, ios_q, ios_d, stb_q, stb_d, rw_q, rw_d, bus_on;
  logic push, pop, carry, take_ok;
  logic [15:0] top;
  logic ready_m, ready_s, bio_m, bio_s;

  // Both pins come from outside the core clock, so each passes two stages.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ready_m <= 1'b0;
      ready_s <= 1'b0;
      bio_m <= 1'b1;
      bio_s <= 1'b1;
    end else begin
      ready_m <= READY;
      ready_s <= ready_m;
      bio_m <= BIO_N;
      bio_s <= bio_m;
    end
  end

  prr_stack #(
    .DEPTH(STACK_LEVELS),
    .WIDTH(ADDR_W)
  ) u_stack (
    .clk(CORE_CLK),
    .rst(RST),
    .push(push),
    .pop(pop),
    .push_data(pc_q),
    .top(top)
  );

  // Condition test: masked ZLVC compare plus the test-pin selector.
  function automatic logic cond_ok(input logic [3:0] m, input logic [3:0] v,
      input logic [1:0] tp, input logic [3:0] f, input logic tc,
      input logic bio_low);
    logic tpok;
    unique case (tp)
      TP_BIO: tpok = bio_low;
      TP_TC: tpok = tc;
      TP_NTC: tpok = !tc;
      TP_NONE: tpok = 1'b1;
    endcase
    return (((f ^ v) & m) == 4'h0) && tpok;
  endfunction

  assign acc = wr_q[IDX_ACCUM];
  assign sum_buffer_register = wr_q[IDX_SUM_BUFFER];
  assign carry = wr_q[IDX_STATUS_ONE][ST1_CARRY_BIT];
  assign take_ok = cond_ok(cmask_q, cval_q, ctp_q,
      {acc == REG_RESET, acc[ACC_W-1],
       wr_q[IDX_STATUS_ZERO][ST0_OV_BIT], carry},
      wr_q[IDX_STATUS_ONE][ST1_TC_BIT], !bio_s);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for the sequencer, register file and bus pins.
  always_comb begin
    state_d = state_q;
    op_d = op_q;
    opnd_d = opnd_q;
    port_d = port_q;
    rpt_d = rpt_q;
    pc_d = pc_q;
    tgt_d = tgt_q;
    dly_d = dly_q;
    cmask_d = cmask_q;
    cval_d = cval_q;
    ctp_d = ctp_q;
    wait_d = wait_q;
    addr_d = addr_q;
    dout_d = dout_q;
    wr_d = wr_q;
    sh_d = sh_q;
    push = 1'b0;
    pop = 1'b0;
    words = (OP_CODE == OP_PORT_WRITE) ? 2'h2 : 2'h1;
    rd_d = (REG_SEL < REG_SEL_W'(NREG)) ? wr_q[REG_SEL] : REG_RESET;
    unique case (state_q)
      ST_IDLE: begin
        if (OP_VALID) begin
          op_d = OP_CODE;
          opnd_d = OP_OPERAND;
          cmask_d = OP_COND_MASK;
          cval_d = OP_COND_VAL;
          ctp_d = OP_COND_TP;
          // A pending delayed return lands once two words have been taken.
          if (dly_q != 2'h0 && words >= dly_q) begin
            pc_d = tgt_q;
            dly_d = 2'h0;
          end else begin
            pc_d = pc_q + ((words == 2'h2) ? TWO_WORDS : ONE_WORD);
            dly_d = (dly_q != 2'h0) ? dly_q - words : 2'h0;
          end
          if (OP_CODE == OP_PORT_WRITE) begin
            port_d = OP_OPERAND;
            addr_d = OP_OPERAND;
            dout_d = OP_DATA;
            state_d = ST_OUT_ADDR;
          end else begin
            state_d = ST_EXEC;
          end
        end else if (INT_TAKE) begin
          push = 1'b1;
          pc_d = INT_VECTOR;
          sh_d = wr_q;
          sh_d[IDX_STATUS_ONE][ST1_XF_BIT] = 1'b0;
        end else if (REG_WR && REG_SEL < REG_SEL_W'(NREG)) begin
          wr_d[REG_SEL] = REG_WDATA &
              ((REG_SEL <= IDX_PRODUCT) ? WIDE_MASK : NARROW_MASK);
        end
      end
      ST_EXEC: begin
        unique case (op_q)
          OP_PORT_WRITE: begin
          end
          OP_INT_RETURN: begin
            pc_d = top;
            pop = 1'b1;
            wr_d = sh_q;
            wr_d[IDX_STATUS_ONE][ST1_XF_BIT] =
                wr_q[IDX_STATUS_ONE][ST1_XF_BIT];
          end
          OP_COND_RETURN: begin
            if (take_ok) begin
              pc_d = top;
              pop = 1'b1;
            end
          end
          OP_COND_RETURN_DLY: begin
            if (take_ok) begin
              tgt_d = top;
              pop = 1'b1;
              dly_d = DELAY_WORDS;
            end
          end
          OP_ROT_LEFT: begin
            // Sign extension plays no part in either rotate.
            wr_d[IDX_STATUS_ONE][ST1_CARRY_BIT] = acc[ACC_W-1];
            wr_d[IDX_ACCUM] = {acc[ACC_W-2:0], sum_buffer_register[ACC_W-1]};
            wr_d[IDX_SUM_BUFFER] = {sum_buffer_register[ACC_W-2:0], carry};
          end
          OP_ROT_RIGHT: begin
            wr_d[IDX_STATUS_ONE][ST1_CARRY_BIT] = sum_buffer_register[0];
            wr_d[IDX_ACCUM] = {carry, acc[ACC_W-1:1]};
            wr_d[IDX_SUM_BUFFER] = {acc[0], sum_buffer_register[ACC_W-1:1]};
          end
          OP_STACK_POP: begin
            wr_d[IDX_ACCUM] = {HALF_ZERO, top};
            pop = 1'b1;
          end
          OP_REPEAT: rpt_d = opnd_q;
        endcase
        // A repeat loads the count and leaves; it never loops on itself.
        if (op_q != OP_REPEAT && rpt_q != HALF_ZERO) begin
          rpt_d = rpt_q - COUNT_STEP;
        end else begin
          state_d = ST_IDLE;
        end
      end
      ST_OUT_ADDR: begin
        wait_d = WAIT_STATES;
        state_d = ST_OUT_EXTERNAL_STROBE;
      end
      ST_OUT_EXTERNAL_STROBE: begin
        // Configured waits first, then the peripheral may stretch further.
        if (wait_q != '0) begin
          wait_d = wait_q - WAIT_BITS'(1);
        end else if (ready_s) begin
          state_d = ST_OUT_END;
        end
      end
      ST_OUT_END: begin
        if (rpt_q != HALF_ZERO) begin
          rpt_d = rpt_q - COUNT_STEP;
          port_d = port_q + PORT_STEP;
          addr_d = port_q + PORT_STEP;
          dout_d = OP_DATA;
          state_d = ST_OUT_ADDR;
        end else begin
          state_d = ST_IDLE;
        end
      end
    endcase
    // Pins are registered from the next state so they carry no glitches.
    bus_on = (state_d == ST_OUT_ADDR) || (state_d == ST_OUT_EXTERNAL_STROBE) ||
        (state_d == ST_OUT_END);
    ios_d = !bus_on;
    rw_d = !bus_on;
    oe_d = bus_on;
    stb_d = (state_d != ST_OUT_EXTERNAL_STROBE);
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      state_q <= ST_IDLE;
      op_q <= OP_PORT_WRITE;
      opnd_q <= '0;
      port_q <= '0;
      rpt_q <= '0;
      pc_q <= PC_RESET;
      tgt_q <= PC_RESET;
      dly_q <= '0;
      cmask_q <= '0;
      cval_q <= '0;
      ctp_q <= TP_NONE;
      wait_q <= '0;
      addr_q <= '0;
      dout_q <= '0;
      rd_q <= REG_RESET;
      oe_q <= 1'b0;
      ios_q <= 1'b1;
      stb_q <= 1'b1;
      rw_q <= 1'b1;
      for (int i = 0; i < NREG; i++) begin
        wr_q[i] <= REG_RESET;
        sh_q[i] <= REG_RESET;
      end
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      opnd_q <= opnd_d;
      port_q <= port_d;
      rpt_q <= rpt_d;
      pc_q <= pc_d;
      tgt_q <= tgt_d;
      dly_q <= dly_d;
      cmask_q <= cmask_d;
      cval_q <= cval_d;
      ctp_q <= ctp_d;
      wait_q <= wait_d;
      addr_q <= addr_d;
      dout_q <= dout_d;
      rd_q <= rd_d;
      oe_q <= oe_d;
      ios_q <= ios_d;
      stb_q <= stb_d;
      rw_q <= rw_d;
      wr_q <= wr_d;
      sh_q <= sh_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; the data word is taken again whenever a repeated write restarts.
  assign OP_READY = (state_q == ST_IDLE);
  assign DATA_NEXT = (state_q == ST_OUT_END) && (rpt_q != HALF_ZERO);
  assign REG_RD_DATA = rd_q;
  assign PC_OUT = pc_q;
  assign STACK_TOP = top;
  assign XF_OUT = wr_q[IDX_STATUS_ONE][ST1_XF_BIT];
  assign ADDR_BUS = addr_q;
  assign DATA_BUS_O = dout_q;
  assign DATA_BUS_OE = oe_q;
  assign IO_SPACE_SELECT_N = ios_q;
  assign EXTERNAL_STROBE_N = stb_q;
  assign RW = rw_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the sequencer.
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  AST_STROBE_IO: assert property ($fell(EXTERNAL_STROBE_N) |->
      !IO_SPACE_SELECT_N && !RW && DATA_BUS_OE && ADDR_BUS == port_q)
    else $error("strobe fell outside an I/O write");
  AST_WAIT_LEN: assert property ((state_q == ST_OUT_EXTERNAL_STROBE &&
      $past(state_q) == ST_OUT_ADDR && wait_q == WAIT_BITS'(2)) |->
      (!EXTERNAL_STROBE_N)[*3])
    else $error("strobe shorter than the wait states");
  AST_PORT_STEP: assert property ((DATA_NEXT) |=>
      port_q == $past(port_q) + PORT_STEP && rpt_q == $past(rpt_q) - COUNT_STEP)
    else $error("port address did not step");
  AST_OUT_PC: assert property ((OP_READY && OP_VALID &&
      OP_CODE == OP_PORT_WRITE && dly_q == 2'h0) |=>
      PC_OUT == $past(pc_q) + TWO_WORDS ##1 !IO_SPACE_SELECT_N)
    else $error("port write did not advance PC by two");
  AST_INTERRUPT_RETURN_INSTR_PC: assert property ((state_q == ST_EXEC &&
      op_q == OP_INT_RETURN) |=> PC_OUT == $past(top) && OP_READY)
    else $error("interrupt return PC wrong");
  AST_XF_HOLD: assert property ((state_q == ST_EXEC &&
      op_q == OP_INT_RETURN) |=> $stable(XF_OUT))
    else $error("external flag changed on interrupt return");
  AST_ROL_CARRY: assert property ((state_q == ST_EXEC &&
      op_q == OP_ROT_LEFT) |=> carry == $past(acc[ACC_W-1]) &&
      sum_buffer_register[0] == $past(carry) && acc[0] == $past(sum_buffer_register[ACC_W-1]))
    else $error("left rotate chain wrong");
  AST_ROR_CARRY: assert property ((state_q == ST_EXEC &&
      op_q == OP_ROT_RIGHT) |=> carry == $past(sum_buffer_register[0]) &&
      acc[ACC_W-1] == $past(carry))
    else $error("right rotate chain wrong");
  AST_POP_ACC: assert property ((state_q == ST_EXEC &&
      op_q == OP_STACK_POP) |=> acc == {HALF_ZERO, $past(top)})
    else $error("stack pop accumulator wrong");
  AST_NO_REREPEAT: assert property ((state_q == ST_EXEC &&
      op_q == OP_REPEAT) |=> OP_READY && rpt_q == $past(opnd_q))
    else $error("repeat instruction was repeated");

endmodule

//--- verilog/prr_pkg.sv
package prr_pkg;

  // Widths of the external bus, the accumulator pair and the stack.
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int ACC_W = 32;
  localparam int STACK_DEPTH = 8;
  localparam int WAIT_W = 3;
  localparam int REG_SEL_W = 4;
  localparam int NREG = 11;

  // Indices of the working registers; the shadow copy uses the same ones.
  localparam logic [3:0] IDX_ACCUM = 4'h0;
  localparam logic [3:0] IDX_SUM_BUFFER = 4'h1;
  localparam logic [3:0] IDX_PRODUCT = 4'h2;
  localparam logic [3:0] IDX_STATUS_ZERO = 4'h3;
  localparam logic [3:0] IDX_STATUS_ONE = 4'h4;
  localparam logic [3:0] IDX_MODE_STATUS = 4'h5;
  localparam logic [3:0] IDX_AUX_COMPARE = 4'h6;
  localparam logic [3:0] IDX_INDEX = 4'h7;
  localparam logic [3:0] IDX_MULTIPLICAND = 4'h8;
  localparam logic [3:0] IDX_SHIFT_COUNT = 4'h9;
  localparam logic [3:0] IDX_BIT_SELECT = 4'hA;

  // Flag positions inside the two status words.
  localparam int ST0_OV_BIT = 12;
  localparam int ST1_TC_BIT = 11;
  localparam int ST1_CARRY_BIT = 9;
  localparam int ST1_XF_BIT = 4;

  // Reset values and fixed steps.
  localparam logic [ACC_W-1:0] REG_RESET = 32'h00000000;
  localparam logic [ACC_W-1:0] WIDE_MASK = 32'hFFFFFFFF;
  localparam logic [ACC_W-1:0] NARROW_MASK = 32'h0000FFFF;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] ONE_WORD = 16'h0001;
  localparam logic [15:0] TWO_WORDS = 16'h0002;
  localparam logic [15:0] PORT_STEP = 16'h0001;
  localparam logic [15:0] COUNT_STEP = 16'h0001;
  localparam logic [15:0] HALF_ZERO = 16'h0000;
  localparam logic [1:0] DELAY_WORDS = 2'h2;

  // Test-pin / test-control selector of a conditional return.
  localparam logic [1:0] TP_BIO = 2'h0;
  localparam logic [1:0] TP_TC = 2'h1;
  localparam logic [1:0] TP_NTC = 2'h2;
  localparam logic [1:0] TP_NONE = 2'h3;

  typedef enum logic [2:0] {
    OP_PORT_WRITE,
    OP_INT_RETURN,
    OP_COND_RETURN,
    OP_COND_RETURN_DLY,
    OP_ROT_LEFT,
    OP_ROT_RIGHT,
    OP_STACK_POP,
    OP_REPEAT
  } prr_op_t;

endpackage

//--- verilog/prr_stack.sv
`timescale 1ns/1ps
module prr_stack #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic push,
  input wire logic pop,
  input wire logic [WIDTH-1:0] push_data,
  output logic [WIDTH-1:0] top
);

  logic [WIDTH-1:0] lvl_q [DEPTH];
  logic [WIDTH-1:0] lvl_d [DEPTH];

  if (DEPTH < 2) begin : g_chk
    $error("prr_stack needs at least two levels");
  end

  // A pop moves every level up and leaves the bottom entry duplicated.
  always_comb begin
    lvl_d = lvl_q;
    if (push) begin
      for (int i = DEPTH - 1; i > 0; i--) begin
        lvl_d[i] = lvl_q[i-1];
      end
      lvl_d[0] = push_data;
    end else if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        lvl_d[i] = lvl_q[i+1];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        lvl_q[i] <= '0;
      end
    end else begin
      lvl_q <= lvl_d;
    end
  end

  assign top = lvl_q[0];

endmodule

//--- test/prr_io_model.sv
`timescale 1ns/1ps
// Port-bus peripheral: logs every write and can stretch the strobe phase.
module prr_io_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic sel_n,
  input wire logic strobe_n,
  input wire logic rw,
  input wire logic [15:0] addr,
  input wire logic [15:0] data,
  input wire logic [3:0] slow,
  output logic ready
);
  logic [33:0] log_q [0:15];
  logic [33:0] cur_q;
  int n_q;
  int stb_q;
  int sel_q;
  int stb_len;
  int sel_len;

  ////////////////////////////////////////////////////////////////////////////
  // Ready idles high like a pulled-up line; from the second strobe cycle
  // it drops for slow minus one cycles so that slow devices lengthen the access.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ready <= 1'b1;
      n_q <= 0;
      stb_q <= 0;
      sel_q <= 0;
      stb_len <= 0;
      sel_len <= 0;
      cur_q <= 34'h0;
    end else begin
      if (!strobe_n) begin
        stb_q <= stb_q + 1;
        ready <= (stb_q + 1 >= slow);
        cur_q <= {rw, sel_n, addr, data};
      end else begin
        ready <= 1'b1;
        if (stb_q != 0) begin
          log_q[n_q % 16] <= cur_q;
          n_q <= n_q + 1;
          stb_len <= stb_q;
          stb_q <= 0;
        end
      end
      if (!sel_n) begin
        sel_q <= sel_q + 1;
      end else if (sel_q != 0) begin
        sel_len <= sel_q;
        sel_q <= 0;
      end
    end
  end
endmodule

//--- test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import prr_pkg::*;
  logic CORE_CLK = 1'b0;
  logic RST = 1'b1;
  logic OP_VALID = 1'b0;
  prr_op_t OP_CODE = OP_ROT_LEFT;
  logic [15:0] OP_OPERAND = 16'h0000;
  logic [3:0] OP_COND_MASK = 4'h0;
  logic [3:0] OP_COND_VAL = 4'h0;
  logic [1:0] OP_COND_TP = TP_NONE;
  logic [15:0] OP_DATA = 16'h0000;
  logic [2:0] WAIT_STATES = 3'h0;
  logic INT_TAKE = 1'b0;
  logic [15:0] INT_VECTOR = 16'h0000;
  logic REG_WR = 1'b0;
  logic [3:0] REG_SEL = 4'h0;
  logic [31:0] REG_WDATA = 32'h00000000;
  logic BIO_N = 1'b1;
  logic [3:0] slow = 4'h0;
  logic OP_READY, DATA_NEXT, XF_OUT, DATA_BUS_OE, READY, RW;
  logic IO_SPACE_SELECT_N, EXTERNAL_STROBE_N;
  logic [31:0] REG_RD_DATA;
  logic [15:0] PC_OUT, STACK_TOP, ADDR_BUS, DATA_BUS_O;
  logic [15:0] sk [0:7];
  int errors, total_checks, epc;

  always #50 CORE_CLK = ~CORE_CLK;

  prr_exec prr_exec_i (.CORE_CLK(CORE_CLK), .RST(RST), .OP_VALID(OP_VALID),
    .OP_READY(OP_READY), .OP_CODE(OP_CODE), .OP_OPERAND(OP_OPERAND),
    .OP_COND_MASK(OP_COND_MASK), .OP_COND_VAL(OP_COND_VAL),
    .OP_COND_TP(OP_COND_TP), .OP_DATA(OP_DATA), .DATA_NEXT(DATA_NEXT),
    .WAIT_STATES(WAIT_STATES), .INT_TAKE(INT_TAKE), .INT_VECTOR(INT_VECTOR),
    .REG_WR(REG_WR), .REG_SEL(REG_SEL), .REG_WDATA(REG_WDATA),
    .REG_RD_DATA(REG_RD_DATA), .PC_OUT(PC_OUT), .STACK_TOP(STACK_TOP),
    .XF_OUT(XF_OUT), .ADDR_BUS(ADDR_BUS), .DATA_BUS_O(DATA_BUS_O),
    .DATA_BUS_OE(DATA_BUS_OE), .IO_SPACE_SELECT_N(IO_SPACE_SELECT_N),
    .EXTERNAL_STROBE_N(EXTERNAL_STROBE_N), .RW(RW), .READY(READY),
    .BIO_N(BIO_N));

  prr_io_model prr_io_model_i (.clk(CORE_CLK), .rst(RST),
    .sel_n(IO_SPACE_SELECT_N), .strobe_n(EXTERNAL_STROBE_N), .rw(RW),
    .addr(ADDR_BUS), .data(DATA_BUS_O), .slow(slow), .ready(READY));

  ////////////////////////////////////////////////////////////////////////////
  // Verdict; also the landing place of any wait that runs out.
  task automatic stop_test;
    if (errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Four-state compare so that an unknown never matches.
  task automatic check(input string nm, input logic [33:0] e,
                       input logic [33:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Inputs always move the same 10 ns after a rising edge.
  task automatic tick;
    @(posedge CORE_CLK);
    #10;
  endtask

  task automatic wait_rdy;
    int k;
    for (k = 0; k < 300 && OP_READY !== 1'b1; k++) tick();
    if (OP_READY !== 1'b1) begin
      errors++;
      stop_test();
    end
  endtask

  // Reference stack: push drops the bottom, pop duplicates it.
  task automatic push(input logic [15:0] x);
    for (int i = 7; i > 0; i--) sk[i] = sk[i-1];
    sk[0] = x;
  endtask

  task automatic pop;
    for (int i = 0; i < 7; i++) sk[i] = sk[i+1];
  endtask

  // Offer one instruction and hold it until the accepting edge.
  task automatic issue(input prr_op_t op, input logic [15:0] opr);
    OP_CODE = op;
    OP_OPERAND = opr;
    OP_VALID = 1'b1;
    wait_rdy();
    tick();
    OP_VALID = 1'b0;
    epc = epc + ((op == OP_PORT_WRITE) ? 2 : 1);
  endtask

  task automatic done;
    wait_rdy();
    tick();
    check("pc", epc[15:0], PC_OUT);
    check("stack top", sk[0], STACK_TOP);
  endtask

  task automatic wreg(input int sel, input logic [31:0] v);
    REG_SEL = sel[3:0];
    REG_WDATA = v;
    REG_WR = 1'b1;
    tick();
    REG_WR = 1'b0;
  endtask

  task automatic rreg(input int sel, output logic [31:0] v);
    REG_SEL = sel[3:0];
    tick();
    v = REG_RD_DATA;
  endtask

  task automatic int_take(input logic [15:0] vec);
    INT_VECTOR = vec;
    INT_TAKE = 1'b1;
    tick();
    INT_TAKE = 1'b0;
    push(epc[15:0]);
    epc = vec;
    tick();
    done();
  endtask

  // Distinct per-register patterns; the status word one pattern toggles
  // the flag bit between the two sets.
  function automatic logic [31:0] val(input int i, input bit k);
    logic [31:0] v;
    v = 32'h13572468 ^ (32'h01010101 * i);
    if (i == 4) v[4] = 1'b0;
    if (k) v = ~v;
    if (i >= 3) v = v & 32'h0000FFFF;
    return v;
  endfunction

  function automatic logic [15:0] wd(input logic [15:0] pa, input int k);
    return 16'hA5C3 ^ (pa + k[15:0]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Port write, optionally repeated, fed word by word on each data request.
  task automatic t_pw(input logic [15:0] pa, input int n, input int w,
                      input int s);
    int k, c, base;
    logic nx;
    base = prr_io_model_i.n_q;
    WAIT_STATES = w[2:0];
    slow = s[3:0];
    if (n > 0) issue(OP_REPEAT, n[15:0]);
    OP_DATA = wd(pa, 0);
    issue(OP_PORT_WRITE, pa);
    k = 1;
    OP_DATA = wd(pa, 1);
    for (c = 0; c < 300 && OP_READY !== 1'b1; c++) begin
      nx = DATA_NEXT;
      tick();
      if (nx) begin
        k++;
        OP_DATA = wd(pa, k);
      end
    end
    done();
    check("writes", n + 1, prr_io_model_i.n_q - base);
    for (k = 0; k <= n; k++) begin
      c = (base + k) % 16;
      check("write", {2'b00, pa + k[15:0], wd(pa, k)},
            prr_io_model_i.log_q[c]);
    end
    if (n == 0 && s == 0)
      check("select len", 3 + w, prr_io_model_i.sel_len);
    // A slow device drops ready on the first strobe edge; the two-stage
    // synchroniser then adds three cycles as long as the waits last at least its three-cycle delay and at most slow plus two.
    if (s == 0) check("strobe len", 1 + w, prr_io_model_i.stb_len);
    else check("stretched", s + 3, prr_io_model_i.stb_len);
  endtask

  // Rotate through carry, accumulator and buffer after optional repeats.
  task automatic t_rot(input prr_op_t op, input logic [31:0] a,
                       input logic [31:0] b, input logic c,
                       input int r1, input int r2);
    int k, t;
    logic [64:0] ch;
    logic [31:0] v;
    wreg(IDX_ACCUM, a);
    wreg(IDX_SUM_BUFFER, b);
    wreg(IDX_STATUS_ONE, {22'h000000, c, 9'h000});
    if (r1 >= 0) issue(OP_REPEAT, r1[15:0]);
    if (r2 >= 0) issue(OP_REPEAT, r2[15:0]);
    issue(op, 16'h0000);
    done();
    t = (r2 >= 0) ? r2 + 1 : (r1 >= 0) ? r1 + 1 : 1;
    ch = {c, a, b};
    for (k = 0; k < t; k++)
      ch = (op == OP_ROT_LEFT) ? {ch[63:0], ch[64]} : {ch[0], ch[64:1]};
    rreg(IDX_ACCUM, v);
    check("acc", ch[63:32], v);
    rreg(IDX_SUM_BUFFER, v);
    check("buffer", ch[31:0], v);
    rreg(IDX_STATUS_ONE, v);
    check("carry", ch[64], v[9]);
  endtask

  // Interrupt entry saves the set; return brings it back but the flag.
  task automatic t_shadow;
    logic [31:0] v, e;
    for (int i = 0; i < NREG; i++) wreg(i, val(i, 0));
    int_take(16'h0400);
    for (int i = 0; i < NREG; i++) wreg(i, val(i, 1));
    issue(OP_INT_RETURN, 16'h0000);
    epc = sk[0];
    pop();
    done();
    for (int i = 0; i < NREG; i++) begin
      rreg(i, v);
      e = val(i, 0) | ((i == 4) ? 32'h10 : 32'h0);
      check("restored", e, v);
    end
    check("flag pin", 1'b1, XF_OUT);
  endtask

  task automatic t_cret(input logic [3:0] m, input logic [3:0] cv,
                        input logic [1:0] tp, input logic bio, input bit tk);
    BIO_N = bio;
    wreg(IDX_ACCUM, 32'h00000000);
    wreg(IDX_STATUS_ONE, 32'h00000000);
    int_take(16'h0200 + {12'h000, m});
    OP_COND_MASK = m;
    OP_COND_VAL = cv;
    OP_COND_TP = tp;
    issue(OP_COND_RETURN, 16'h0000);
    if (tk) begin
      epc = sk[0];
      pop();
    end
    done();
  endtask

  // Delayed return: two following words run before the jump.
  task automatic t_dly;
    logic [15:0] tgt;
    int_take(16'h0300);
    OP_COND_MASK = 4'h0;
    OP_COND_TP = TP_NONE;
    issue(OP_COND_RETURN_DLY, 16'h0000);
    tgt = sk[0];
    pop();
    done();
    issue(OP_ROT_LEFT, 16'h0000);
    done();
    issue(OP_ROT_RIGHT, 16'h0000);
    epc = tgt;
    done();
  endtask

  task automatic t_pop;
    logic [31:0] v, e;
    for (int i = 0; i < 9; i++) int_take(16'h0100 + i[15:0]);
    for (int i = 0; i < 9; i++) begin
      wreg(IDX_ACCUM, 32'hFFFFFFFF);
      issue(OP_STACK_POP, 16'h0000);
      e = {16'h0000, sk[0]};
      pop();
      done();
      rreg(IDX_ACCUM, v);
      check("popped acc", e, v);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    errors = 0;
    total_checks = 0;
    epc = 0;
    for (int i = 0; i < 8; i++) sk[i] = 16'h0000;
    repeat (5) @(posedge CORE_CLK);
    #10;
    check("reset bus", 5'b11101, {OP_READY, IO_SPACE_SELECT_N,
          EXTERNAL_STROBE_N, DATA_BUS_OE, RW});
    RST = 1'b0;
    tick();
    t_pw(16'h0007, 0, 0, 0);
    t_pw(16'h0015, 0, 2, 0);
    t_pw(16'h0050, 0, 3, 4);
    t_pw(16'hFFFE, 2, 1, 0);
    t_rot(OP_ROT_LEFT, 32'h08080808, 32'hFFFFFFFE, 1'b1, -1, -1);
    t_rot(OP_ROT_RIGHT, 32'h08080808, 32'hFFFFFFFE, 1'b1, -1, -1);
    t_rot(OP_ROT_LEFT, 32'h80000001, 32'h7FFFFFFF, 1'b0, 3, 1);
    t_shadow();
    t_cret(4'h1, 4'h1, TP_NONE, 1'b1, 1'b0);
    t_cret(4'h1, 4'h0, TP_NONE, 1'b1, 1'b1);
    t_cret(4'h8, 4'h8, TP_NONE, 1'b1, 1'b1);
    t_cret(4'h9, 4'h9, TP_NONE, 1'b1, 1'b0);
    t_cret(4'h4, 4'h4, TP_NONE, 1'b1, 1'b0);
    t_cret(4'h0, 4'h0, TP_BIO, 1'b1, 1'b0);
    t_cret(4'h0, 4'h0, TP_BIO, 1'b0, 1'b1);
    t_cret(4'h0, 4'h0, TP_TC, 1'b1, 1'b0);
    t_cret(4'h0, 4'h0, TP_NTC, 1'b1, 1'b1);
    t_dly();
    t_pop();
    stop_test();
  end
endmodule
